// ### rtl/bmseq_conv_timer.sv
// conversion timer: counts to terminal count from ratio and channel
`timescale 1ns/1ps
`default_nettype none
module bmseq_conv_timer #(
  parameter int BASE_CYC = bmseq_pkg::TCONV128_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] ratio_code,
  input wire logic with_press,
  output logic done
);
  logic [31:0] cnt_q;
  logic [31:0] term_q;
  logic run_q;
  logic [31:0] term_d;
  always_comb begin
    // ratio code 5 is the shortest; each lower code doubles, pressure doubles again
    term_d = BASE_CYC << (3'(bmseq_pkg::RATIO_MAX_CODE - ratio_code) + 3'(with_press));
  end
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      term_q <= '0;
      done <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
      cnt_q <= 32'h1;
      term_q <= term_d;
      done <= 1'b0;
    end else if (run_q) begin
      done <= (cnt_q == term_q - 32'h1);
      run_q <= (cnt_q != term_q - 32'h1);
      cnt_q <= cnt_q + 32'h1;
    end else begin
      done <= 1'b0;
    end
  end
endmodule // bmseq_conv_timer
`default_nettype wire

// ### rtl/bmseq_pkg.sv
// package: constants and carrier types for the measurement sequencer
`default_nettype none
package bmseq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int POWERUP_US = 400;
  localparam int POWERUP_CYC = POWERUP_US * (CLK_HZ / 1000000);
  // temperature conversion time at ratio 128, in tenths of ms
  localparam int TCONV128_TENTH_MS = 21;
  localparam int TCONV128_CYC = TCONV128_TENTH_MS * (CLK_HZ / 10000);
  localparam int CAL_CYC = 16;
  // ----------------------------------------
  // command encodings
  // ----------------------------------------
  localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
  localparam logic [2:0] CVT_PREFIX = 3'h2;
  localparam logic [1:0] CHAN_PT = 2'h0;
  localparam logic [1:0] CHAN_T = 2'h2;
  localparam logic [2:0] RATIO_MAX_CODE = 3'h5;
  localparam int CVT_PREFIX_POS = 5;
  localparam int RATIO_POS = 2;
  localparam int DATA_W = 24;
  localparam int ALT_SHIFT = 4;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {BMSEQ_SAMPLE_T, BMSEQ_SAMPLE_P} bmseq_sample_kind_t;
  typedef struct packed {
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] press;
    logic [DATA_W-1:0] alt;
  } bmseq_results_t;
  typedef struct packed {
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] press;
    logic [DATA_W-1:0] alt;
  } bmseq_thresh_t;
endpackage
`default_nettype wire

// ### rtl/bmseq_top.sv
// measurement sequencer: power-up, calibration, conversions, events
// ----------------------------------------
// Functional notes
// - power-on runs init about 400 us, sleeps
// - ready flag set after power-up
// - sleep idle until valid command
// - pressure measured after automatic temperature
// - results kept while sleeping
// - ratio picks one of six durations
// - conversion times double per ratio step
// - compensation off gives raw values
// - altitude updated after pressure conversion
// - one calibration per power or reset
// - return to sleep after command
// - thresholds compared against results
// - events drive interrupt outputs
// - samples are 24-bit
// - programmed trim bank replaces factory trims
// - command is 010, ratio, channel
// - ratio codes 000..101 map 4096..128
// - bad channel or ratio fails conversion
// - soft reset aborts, reruns power-up
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bmseq_top #(
  parameter int POWERUP_CYC = bmseq_pkg::POWERUP_CYC,
  parameter int CONV_BASE_CYC = bmseq_pkg::TCONV128_CYC,
  parameter int CAL_CYC = bmseq_pkg::CAL_CYC
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire logic COMP_EN,
  input wire logic TRIM_BANK_NEW,
  input wire logic [23:0] TRIM_FACTORY,
  input wire logic [23:0] TRIM_USER,
  input wire logic [23:0] ADC_SAMPLE,
  input wire logic [23:0] THR_TEMP,
  input wire logic [23:0] THR_PRESS,
  input wire logic [23:0] THR_ALT,
  output logic DEV_READY,
  output logic BUSY,
  output logic CONV_FAIL,
  output logic [23:0] TEMP_OUT,
  output logic [23:0] PRESS_OUT,
  output logic [23:0] ALT_OUT,
  output logic INT_EVT0,
  output logic INT_EVT1
);
  typedef enum logic [2:0] {ST_POWERUP, ST_CAL, ST_SLEEP, ST_CONV_T, ST_CONV_P} bmseq_state_t;
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [7:0] cmd_q;
  logic cmd_v_q;
  logic soft_rst;
  logic is_cvt;
  logic [2:0] ratio;
  logic [1:0] chan;
  logic cvt_ok;
  bmseq_state_t state_q;
  always_ff @(posedge CORE_CLK) begin
    cmd_v_q <= SYS_RST ? 1'b0 : CMD_VALID;
    cmd_q <= SYS_RST ? 8'h00 : CMD_BYTE;
  end
  assign soft_rst = cmd_v_q && (cmd_q == bmseq_pkg::CMD_SOFT_RESET);
  assign is_cvt = cmd_v_q && (cmd_q[7:bmseq_pkg::CVT_PREFIX_POS] == bmseq_pkg::CVT_PREFIX);
  assign ratio = cmd_q[bmseq_pkg::CVT_PREFIX_POS-1:bmseq_pkg::RATIO_POS];
  assign chan = cmd_q[1:0];
  assign cvt_ok = (ratio <= bmseq_pkg::RATIO_MAX_CODE)
      && (chan == bmseq_pkg::CHAN_PT || chan == bmseq_pkg::CHAN_T);
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic [31:0] wait_q;
  logic with_p_q;
  logic start_conv;
  logic conv_done;
  logic cal_done_q;
  assign start_conv = (state_q == ST_SLEEP) && is_cvt && cvt_ok;
  bmseq_conv_timer #(.BASE_CYC(CONV_BASE_CYC)) u_timer (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .start(start_conv),
    .abort(soft_rst),
    .ratio_code(ratio),
    .with_press(chan == bmseq_pkg::CHAN_PT),
    .done(conv_done)
  );
  // temperature phase takes half of a combined conversion
  logic [31:0] half_q;
  logic [31:0] t_cnt_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || soft_rst) begin
      state_q <= ST_POWERUP;
      wait_q <= '0;
      cal_done_q <= 1'b0;
      with_p_q <= 1'b0;
      half_q <= '0;
      t_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_POWERUP: begin
          wait_q <= wait_q + 32'h1;
          if (wait_q == 32'(POWERUP_CYC - 1)) begin
            state_q <= ST_CAL;
            wait_q <= '0;
          end
        end
        ST_CAL: begin
          wait_q <= wait_q + 32'h1;
          if (wait_q == 32'(CAL_CYC - 1)) begin
            cal_done_q <= 1'b1;
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (start_conv) begin
            with_p_q <= (chan == bmseq_pkg::CHAN_PT);
            half_q <= CONV_BASE_CYC << 3'(bmseq_pkg::RATIO_MAX_CODE - ratio);
            t_cnt_q <= 32'h1;
            state_q <= ST_CONV_T;
          end
        end
        ST_CONV_T: begin
          t_cnt_q <= t_cnt_q + 32'h1;
          if (!with_p_q && conv_done) begin
            state_q <= ST_SLEEP;
          end else if (with_p_q && t_cnt_q == half_q) begin
            state_q <= ST_CONV_P;
          end
        end
        ST_CONV_P: begin
          if (conv_done) begin
            state_q <= ST_SLEEP;
          end
        end
        default: state_q <= ST_POWERUP;
      endcase
    end
  end
  // ----------------------------------------
  // status
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || soft_rst) begin
      DEV_READY <= 1'b0;
      BUSY <= 1'b0;
      CONV_FAIL <= 1'b0;
    end else begin
      DEV_READY <= cal_done_q || (state_q == ST_CAL && wait_q == 32'(CAL_CYC - 1));
      BUSY <= (state_q != ST_SLEEP) && !(state_q != ST_POWERUP && state_q != ST_CAL && conv_done);
      if (state_q == ST_SLEEP && is_cvt) begin
        CONV_FAIL <= !cvt_ok;
      end
    end
  end
  // ----------------------------------------
  // results; trims picked by bank, compensation applied on capture
  // ----------------------------------------
  logic [23:0] trim;
  logic [23:0] sample_c;
  logic t_capture;
  logic p_capture;
  assign trim = TRIM_BANK_NEW ? TRIM_USER : TRIM_FACTORY;
  // carry out of the trim sum is dropped on purpose; results stay 24 bits
  assign sample_c = COMP_EN ? 24'(ADC_SAMPLE + trim) : ADC_SAMPLE;
  assign t_capture = (state_q == ST_CONV_T) && ((with_p_q && t_cnt_q == half_q)
      || (!with_p_q && conv_done));
  assign p_capture = (state_q == ST_CONV_P) && conv_done;
  // results hold through sleep; only a reset clears them
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || soft_rst) begin
      TEMP_OUT <= 24'h000000;
      PRESS_OUT <= 24'h000000;
      ALT_OUT <= 24'h000000;
    end else begin
      if (t_capture) begin
        TEMP_OUT <= sample_c;
      end
      if (p_capture) begin
        PRESS_OUT <= sample_c;
        // crude altitude: falls as pressure rises
        ALT_OUT <= ~(sample_c >> bmseq_pkg::ALT_SHIFT);
      end
    end
  end
  // ----------------------------------------
  // events
  // ----------------------------------------
  logic p_done_q;
  logic t_done_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || soft_rst) begin
      p_done_q <= 1'b0;
      t_done_q <= 1'b0;
      INT_EVT0 <= 1'b0;
      INT_EVT1 <= 1'b0;
    end else begin
      p_done_q <= p_capture;
      t_done_q <= t_capture;
      // level outputs; re-evaluated after every new result
      if (t_done_q) begin
        INT_EVT0 <= TEMP_OUT > THR_TEMP;
      end
      if (p_done_q) begin
        INT_EVT1 <= (PRESS_OUT > THR_PRESS) || (ALT_OUT > THR_ALT);
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  powerup_ready_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(DEV_READY) |-> $past(state_q) == ST_CAL) else $error("ready early");
  sleep_stays_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_SLEEP && !cmd_v_q) |=> state_q == ST_SLEEP) else $error("left sleep");
  bad_cvt_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (state_q == ST_SLEEP && is_cvt && !cvt_ok) |=> CONV_FAIL && state_q == ST_SLEEP)
      else $error("bad conversion accepted");
  soft_rst_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      soft_rst |=> state_q == ST_POWERUP && !DEV_READY) else $error("soft reset");
  p_after_t_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $rose(state_q == ST_CONV_P) |-> $past(t_capture)) else $error("pressure without temp");
  // soft reset in the antecedent too: it clears results at the very edge it is sampled
  hold_sleep_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || soft_rst)
      state_q == ST_SLEEP && !soft_rst |=> $stable(TEMP_OUT) && $stable(PRESS_OUT))
      else $error("lost");
  alt_upd_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || soft_rst)
      p_capture && !soft_rst |=> ALT_OUT == ~(PRESS_OUT >> bmseq_pkg::ALT_SHIFT))
      else $error("alt");
  back_sleep_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || soft_rst)
      p_capture && !soft_rst |=> state_q == ST_SLEEP) else $error("no sleep");
endmodule // bmseq_top
`default_nettype wire

// ### verification/bmseq_host_model.sv
// host model: issues command bytes toward the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module bmseq_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'hA5;
  end
  // ----------------------------------------
  // one-cycle strobe
  // ----------------------------------------
  // byte inverted after the strobe so a stale value is never mistaken for a command
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  endtask
endmodule // bmseq_host_model
`default_nettype wire

// ### verification/tb.sv
// testbench: command sequences against the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  // short counts keep the run brief
  localparam int PU = 20;
  localparam int CB = 10;
  localparam int CAL = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic comp_en = 1'b0;
  logic bank_new = 1'b0;
  logic [23:0] trim_f = 24'h000100;
  logic [23:0] trim_u = 24'h020000;
  logic [23:0] sample = 24'h012345;
  logic [23:0] thr_t = 24'hFFFFFF;
  logic [23:0] thr_p = 24'hFFFFFF;
  logic [23:0] thr_a = 24'hFFFFFF;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic dev_ready, busy, conv_fail, int0, int1;
  logic [23:0] t_out, p_out, a_out, e;
  logic [2:0] br [4] = '{3'h5, 3'h5, 3'h6, 3'h7};
  logic [1:0] bc [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  int n_fail = 0;
  int num_checks = 0;
  int n;
  always #50 clk = ~clk;
  bmseq_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
  bmseq_top #(.POWERUP_CYC(PU), .CONV_BASE_CYC(CB), .CAL_CYC(CAL)) DUT (
    .CORE_CLK(clk), .SYS_RST(rst), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
    .COMP_EN(comp_en), .TRIM_BANK_NEW(bank_new), .TRIM_FACTORY(trim_f),
    .TRIM_USER(trim_u), .ADC_SAMPLE(sample), .THR_TEMP(thr_t), .THR_PRESS(thr_p),
    .THR_ALT(thr_a), .DEV_READY(dev_ready), .BUSY(busy), .CONV_FAIL(conv_fail),
    .TEMP_OUT(t_out), .PRESS_OUT(p_out), .ALT_OUT(a_out), .INT_EVT0(int0),
    .INT_EVT1(int1));
  // ----------------------------------------
  // compare and access tasks
  // ----------------------------------------
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // small slack: launch and capture edges are not part of the terminal count
  task automatic chk_dur(input int got, input int exp);
    num_checks++;
    if (got < exp - 2 || got > exp + 3) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (dev_ready !== 1'b1 && c < 200) begin
      tick(1);
      c++;
    end
  endtask
  task automatic convert(input logic [2:0] r, input logic [1:0] ch, output int c);
    int w;
    w = 0;
    c = 0;
    host.send({3'h2, r, ch});
    while (busy !== 1'b1 && w < 5) begin
      tick(1);
      w++;
    end
    while (busy === 1'b1 && c < 2000) begin
      tick(1);
      c++;
    end
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #1000000;
    n_fail++;
    finish_test();
  end
  initial begin
    tick(2);
    rst = 1'b0;
    chk1(dev_ready, 1'b0);
    host.send(8'h52);
    wait_ready(n);
    chk_dur(n + 2, PU + CAL);
    tick(1);
    chk1(dev_ready, 1'b1);
    chk1(busy, 1'b0);
    chk24(t_out, 24'h000000);
    for (int r = 0; r < 6; r++) begin
      convert(r[2:0], 2'h2, n);
      chk_dur(n, CB << (5 - r));
      chk24(t_out, sample);
      chk24(p_out, 24'h000000);
      chk1(busy, 1'b0);
    end
    // events are re-evaluated only on a new result, so each threshold gets a conversion
    thr_t = 24'h012344;
    convert(3'h5, 2'h2, n);
    chk1(int0, 1'b1);
    thr_t = 24'h012345;
    convert(3'h5, 2'h2, n);
    chk1(int0, 1'b0);
    comp_en = 1'b1;
    bank_new = 1'b1;
    e = sample + trim_u;
    convert(3'h5, 2'h0, n);
    chk_dur(n, 2 * CB);
    chk24(t_out, e);
    chk24(p_out, e);
    bank_new = 1'b0;
    e = sample + trim_f;
    convert(3'h4, 2'h0, n);
    chk_dur(n, 4 * CB);
    chk24(t_out, e);
    chk24(a_out, ~(e >> 4));
    chk1(int1, 1'b0);
    thr_a = ~(e >> 4) - 24'h000001;
    convert(3'h4, 2'h0, n);
    chk1(int1, 1'b1);
    tick(200);
    chk24(p_out, e);
    for (int i = 0; i < 4; i++) begin
      convert(br[i], bc[i], n);
      chk1(conv_fail, 1'b1);
      chk24(p_out, e);
    end
    convert(3'h5, 2'h2, n);
    chk1(conv_fail, 1'b0);
    host.send(8'h40);
    tick(50);
    chk1(busy, 1'b1);
    host.send(8'h06);
    tick(1);
    chk1(busy, 1'b0);
    chk1(dev_ready, 1'b0);
    chk24(t_out, 24'h000000);
    wait_ready(n);
    chk_dur(n, PU + CAL);
    finish_test();
  end
endmodule // tb
`default_nettype wire
